// >>> wras_core.v
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wras_regs.vh"

// Summary of operation
// - Direct operands reach set 1 outside C0H-CFH, never set 2.
// - A pair is an even address and the next odd one.
// - Pair high byte at even address, low byte at odd.
// - Reset sets the pointers to slices C0H and C8H.
// - Field bit 3 picks the first (0) or second (1) pointer.
// - Pointer bits 7:3 form address bits 7:3.
// - Field bits 2:0 form address bits 2:0.
// - A register-mode operand with upper nibble 1100B is a working field.
// - For 8-bit working operands bit 3 picks the pointer.
// - Call pushes the program counter; return pops it.
// - Interrupts push counter and flags; interrupt return pops both.
// - Push decrements before writing; pop increments after reading.
// - Stack pointer high byte at D8H, low byte at D9H.
// - Reset leaves the stack pointer alone; software sets the low byte.
// - Low byte wrap carries or borrows into the high byte.
// - Eight operand addressing modes exist.
// - Pointers sit at D6H and D7H, loadable by instructions.
// - Set 2 is reached only by indirect or indexed addressing.
module wras_core (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        ptr_load_first,
    input  wire        ptr_load_second,
    input  wire [7:0]  ptr_load_data,
    input  wire        acc_valid,
    output wire        acc_ready,
    input  wire [2:0]  acc_mode,
    input  wire [7:0]  acc_field,
    input  wire        acc_pair,
    output reg         acc_done,
    output reg  [7:0]  acc_addr_hi,
    output reg  [7:0]  acc_addr_lo,
    output reg         acc_set2,
    output reg         acc_none,
    output reg         acc_invalid,
    input  wire        stk_valid,
    output wire        stk_ready,
    input  wire [2:0]  stk_cmd,
    input  wire [15:0] stk_pc_in,
    input  wire [7:0]  stk_flags_in,
    input  wire [7:0]  stk_data_in,
    output reg         stk_done,
    output reg  [15:0] stk_pc_out,
    output reg  [7:0]  stk_flags_out,
    output reg  [7:0]  stk_data_out,
    output reg         mem_we,
    output reg         mem_re,
    output reg  [7:0]  mem_addr,
    output reg  [7:0]  mem_wdata,
    input  wire [7:0]  mem_rdata
);

    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_PUSH = 6'b000010;
    localparam [5:0] S_RREQ = 6'b000100;
    localparam [5:0] S_RWT  = 6'b001000;
    localparam [5:0] S_RCAP = 6'b010000;
    localparam [5:0] S_FIN  = 6'b100000;

    reg [7:0]  slice_first_reg;
    reg [7:0]  slice_second_reg;
    reg [7:0]  sp_high_reg;
    reg [7:0]  sp_low_reg;
    reg        err_reg;
    reg [7:0]  last_addr_reg;
    reg [5:0]  state_reg;
    reg [2:0]  cmd_reg;
    reg [1:0]  cnt_reg;
    reg [23:0] queue_reg;
    reg [23:0] col_reg;
    reg        aw_hold_reg;
    reg [11:0] aw_addr_reg;
    reg        w_hold_reg;
    reg [7:0]  w_data_reg;
    reg        w_strb_reg;

    wire [7:0]  gen_hi;
    wire [7:0]  gen_lo;
    wire        gen_set2;
    wire        gen_none;
    wire        gen_invalid;
    wire [15:0] sp_full;
    wire [15:0] sp_dec;
    wire [15:0] sp_inc;
    wire        wr_fire;
    wire        wr_lane;
    reg  [31:0] rd_mux;
    reg         rd_hit;

    ////////////////////////////////////////////////////////////////////////////

    function wras_hit;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            wras_hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx);
        end
    endfunction

    // The full 16-bit step lets a low-byte wrap spill into the high byte.
    function [15:0] wras_sp_step;
        input [15:0] sp;
        input        down;
        begin
            if (down) begin
                wras_sp_step = sp - 16'h0001;
            end else begin
                wras_sp_step = sp + 16'h0001;
            end
        end
    endfunction

    assign sp_full = {sp_high_reg, sp_low_reg};
    assign sp_dec  = wras_sp_step(sp_full, 1'b1);
    assign sp_inc  = wras_sp_step(sp_full, 1'b0);

    ////////////////////////////////////////////////////////////////////////////
    // Operand address formation.

    wras_addr_gen u_addr_gen (
        .ptr_first  (slice_first_reg),
        .ptr_second (slice_second_reg),
        .mode       (acc_mode),
        .field      (acc_field),
        .pair       (acc_pair),
        .addr_hi    (gen_hi),
        .addr_lo    (gen_lo),
        .set2       (gen_set2),
        .none       (gen_none),
        .invalid    (gen_invalid)
    );

    assign acc_ready = 1'b1;

    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_done    <= 1'b0;
            acc_addr_hi <= 8'h00;
            acc_addr_lo <= 8'h00;
            acc_set2    <= 1'b0;
            acc_none    <= 1'b0;
            acc_invalid <= 1'b0;
        end else begin
            acc_done <= acc_valid;
            if (acc_valid) begin
                acc_addr_hi <= gen_hi;
                acc_addr_lo <= gen_lo;
                acc_set2    <= gen_set2;
                acc_none    <= gen_none;
                acc_invalid <= gen_invalid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave. Registers sit in byte lane 0; status also returns the last address in bits 15:8.

    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_lane       = wr_fire && w_strb_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg  <= 1'b0;
            aw_addr_reg  <= 12'h000;
            w_hold_reg   <= 1'b0;
            w_data_reg   <= 8'h00;
            w_strb_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WRAS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wras_hit(aw_addr_reg, `WRAS_IDX_SLICE_FIRST) ||
                    wras_hit(aw_addr_reg, `WRAS_IDX_SLICE_SECOND) ||
                    wras_hit(aw_addr_reg, `WRAS_IDX_SP_HIGH) ||
                    wras_hit(aw_addr_reg, `WRAS_IDX_SP_LOW) ||
                    wras_hit(aw_addr_reg, `WRAS_IDX_STATUS)) begin
                    s_axi_bresp <= `WRAS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `WRAS_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        if (wras_hit(s_axi_araddr, `WRAS_IDX_SLICE_FIRST)) begin
            rd_mux[7:0] = slice_first_reg;
        end else if (wras_hit(s_axi_araddr, `WRAS_IDX_SLICE_SECOND)) begin
            rd_mux[7:0] = slice_second_reg;
        end else if (wras_hit(s_axi_araddr, `WRAS_IDX_SP_HIGH)) begin
            rd_mux[7:0] = sp_high_reg;
        end else if (wras_hit(s_axi_araddr, `WRAS_IDX_SP_LOW)) begin
            rd_mux[7:0] = sp_low_reg;
        end else if (wras_hit(s_axi_araddr, `WRAS_IDX_STATUS)) begin
            rd_mux[`WRAS_STAT_BUSY_BIT] = (state_reg != S_IDLE);
            rd_mux[`WRAS_STAT_ERR_BIT]  = err_reg;
            rd_mux[`WRAS_STAT_ADDR_LSB +: 8] = last_addr_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `WRAS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `WRAS_RESP_OKAY : `WRAS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice pointers and status. Instruction loads win over a bus write.

    always @(posedge aclk) begin
        if (!aresetn) begin
            slice_first_reg  <= `WRAS_RST_SLICE_FIRST;
            slice_second_reg <= `WRAS_RST_SLICE_SECOND;
            err_reg          <= 1'b0;
            last_addr_reg    <= 8'h00;
        end else begin
            if (ptr_load_first) begin
                slice_first_reg <= ptr_load_data;
            end else if (wr_lane && wras_hit(aw_addr_reg, `WRAS_IDX_SLICE_FIRST)) begin
                slice_first_reg <= w_data_reg;
            end
            if (ptr_load_second) begin
                slice_second_reg <= ptr_load_data;
            end else if (wr_lane && wras_hit(aw_addr_reg, `WRAS_IDX_SLICE_SECOND)) begin
                slice_second_reg <= w_data_reg;
            end
            // A new fault in the clearing cycle keeps the flag set.
            if (acc_valid && gen_invalid) begin
                err_reg <= 1'b1;
            end else if (wr_lane && wras_hit(aw_addr_reg, `WRAS_IDX_STATUS) &&
                         w_data_reg[`WRAS_STAT_ERR_BIT]) begin
                err_reg <= 1'b0;
            end
            if (acc_valid && !gen_none) begin
                last_addr_reg <= gen_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack sequencer. The stack pointer has no reset: its value survives.

    assign stk_ready = (state_reg == S_IDLE);

    always @(posedge aclk) begin
        if (state_reg == S_PUSH) begin
            {sp_high_reg, sp_low_reg} <= sp_dec;
        end else if (state_reg == S_RCAP) begin
            {sp_high_reg, sp_low_reg} <= sp_inc;
        end else if (wr_lane && wras_hit(aw_addr_reg, `WRAS_IDX_SP_HIGH)) begin
            sp_high_reg <= w_data_reg;
        end else if (wr_lane && wras_hit(aw_addr_reg, `WRAS_IDX_SP_LOW)) begin
            sp_low_reg <= w_data_reg;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= S_IDLE;
            cmd_reg       <= `WRAS_STK_PUSH;
            cnt_reg       <= 2'h0;
            queue_reg     <= 24'h000000;
            col_reg       <= 24'h000000;
            stk_done      <= 1'b0;
            stk_pc_out    <= 16'h0000;
            stk_flags_out <= 8'h00;
            stk_data_out  <= 8'h00;
            mem_we        <= 1'b0;
            mem_re        <= 1'b0;
            mem_addr      <= 8'h00;
            mem_wdata     <= 8'h00;
        end else begin
            stk_done <= 1'b0;
            mem_we   <= 1'b0;
            mem_re   <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (stk_valid) begin
                        cmd_reg <= stk_cmd;
                        case (stk_cmd)
                            `WRAS_STK_PUSH: begin
                                queue_reg <= {stk_data_in, 16'h0000};
                                cnt_reg   <= 2'h1;
                                state_reg <= S_PUSH;
                            end
                            `WRAS_STK_CALL: begin
                                // Low byte first leaves the high byte on top of the stack.
                                queue_reg <= {stk_pc_in[7:0], stk_pc_in[15:8], 8'h00};
                                cnt_reg   <= 2'h2;
                                state_reg <= S_PUSH;
                            end
                            `WRAS_STK_INTR: begin
                                queue_reg <= {stk_pc_in[7:0], stk_pc_in[15:8], stk_flags_in};
                                cnt_reg   <= 2'h3;
                                state_reg <= S_PUSH;
                            end
                            `WRAS_STK_POP: begin
                                cnt_reg   <= 2'h1;
                                state_reg <= S_RREQ;
                            end
                            `WRAS_STK_RET: begin
                                cnt_reg   <= 2'h2;
                                state_reg <= S_RREQ;
                            end
                            `WRAS_STK_INTERRUPT_RETURN: begin
                                cnt_reg   <= 2'h3;
                                state_reg <= S_RREQ;
                            end
                            default: begin
                                state_reg <= S_FIN;
                            end
                        endcase
                    end
                end
                S_PUSH: begin
                    mem_we    <= 1'b1;
                    mem_addr  <= sp_dec[7:0];
                    mem_wdata <= queue_reg[23:16];
                    queue_reg <= {queue_reg[15:0], 8'h00};
                    cnt_reg   <= cnt_reg - 2'h1;
                    state_reg <= (cnt_reg == 2'h1) ? S_FIN : S_PUSH;
                end
                S_RREQ: begin
                    mem_re    <= 1'b1;
                    mem_addr  <= sp_low_reg;
                    state_reg <= S_RWT;
                end
                S_RWT: begin
                    state_reg <= S_RCAP;
                end
                S_RCAP: begin
                    col_reg   <= {col_reg[15:0], mem_rdata};
                    cnt_reg   <= cnt_reg - 2'h1;
                    state_reg <= (cnt_reg == 2'h1) ? S_FIN : S_RREQ;
                end
                S_FIN: begin
                    stk_done  <= 1'b1;
                    state_reg <= S_IDLE;
                    if (cmd_reg == `WRAS_STK_POP) begin
                        stk_data_out <= col_reg[7:0];
                    end else if (cmd_reg == `WRAS_STK_RET) begin
                        stk_pc_out <= col_reg[15:0];
                    end else if (cmd_reg == `WRAS_STK_INTERRUPT_RETURN) begin
                        stk_flags_out <= col_reg[23:16];
                        stk_pc_out    <= col_reg[15:0];
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

endmodule // wras_core

`default_nettype wire

// >>> wras_regs.vh
`ifndef WRAS_REGS_VH
`define WRAS_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define WRAS_IDX_SLICE_FIRST   8'hD6
`define WRAS_IDX_SLICE_SECOND  8'hD7
`define WRAS_IDX_SP_HIGH       8'hD8
`define WRAS_IDX_SP_LOW        8'hD9
`define WRAS_IDX_STATUS        8'hE0

// Status register fields.
`define WRAS_STAT_BUSY_BIT     0
`define WRAS_STAT_ERR_BIT      1
`define WRAS_STAT_ADDR_LSB     8

// Reset values of the slice pointers.
`define WRAS_RST_SLICE_FIRST   8'hC0
`define WRAS_RST_SLICE_SECOND  8'hC8

// Operand decoding constants.
`define WRAS_WORK_TAG          4'hC
`define WRAS_SET2_BASE         8'hC0

// Operand addressing modes.
`define WRAS_MODE_REG          3'h0
`define WRAS_MODE_IND_REG      3'h1
`define WRAS_MODE_INDEXED      3'h2
`define WRAS_MODE_DIRECT       3'h3
`define WRAS_MODE_IND_ADDR     3'h4
`define WRAS_MODE_RELATIVE     3'h5
`define WRAS_MODE_IMMEDIATE    3'h6
`define WRAS_MODE_WORK4        3'h7

// Stack commands.
`define WRAS_STK_PUSH          3'h0
`define WRAS_STK_POP           3'h1
`define WRAS_STK_CALL          3'h2
`define WRAS_STK_RET           3'h3
`define WRAS_STK_INTR          3'h4
`define WRAS_STK_INTERRUPT_RETURN          3'h5

// AXI responses.
`define WRAS_RESP_OKAY         2'h0
`define WRAS_RESP_SLVERR       2'h2

`endif

// >>> wras_addr_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "wras_regs.vh"

module wras_addr_gen (
    input  wire [7:0] ptr_first,
    input  wire [7:0] ptr_second,
    input  wire [2:0] mode,
    input  wire [7:0] field,
    input  wire       pair,
    output reg  [7:0] addr_hi,
    output reg  [7:0] addr_lo,
    output reg        set2,
    output reg        none,
    output reg        invalid
);

    reg       work;
    reg [7:0] ptr;
    reg [7:0] base;

    always @* begin
        work    = (mode == `WRAS_MODE_WORK4) ||
                  ((mode == `WRAS_MODE_REG) && (field[7:4] == `WRAS_WORK_TAG));
        ptr     = field[3] ? ptr_second : ptr_first;
        base    = 8'h00;
        set2    = 1'b0;
        none    = 1'b0;
        invalid = 1'b0;
        if (work) begin
            // Pointer bits 2:0 never reach the address.
            base = {ptr[7:3], field[2:0]};
        end else if (mode == `WRAS_MODE_REG) begin
            base = field;
        end else if ((mode == `WRAS_MODE_IND_REG) || (mode == `WRAS_MODE_INDEXED)) begin
            base = field;
            set2 = (field >= `WRAS_SET2_BASE);
        end else begin
            none = 1'b1;
        end
        if (pair && !none) begin
            invalid = base[0];
            addr_hi = {base[7:1], 1'b0};
            addr_lo = {base[7:1], 1'b1};
        end else begin
            addr_hi = base;
            addr_lo = base;
        end
    end

endmodule // wras_addr_gen

`default_nettype wire

// >>> wras_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stack memory, one-cycle read; idle data toggles so a stale capture fails.
module wras_mem_model (
    input  wire logic       aclk,
    input  wire logic       mem_we,
    input  wire logic       mem_re,
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    output var  logic [7:0] mem_rdata
);
    logic [7:0] mem [0:255];
    initial mem_rdata = 8'h00;
    always @(posedge aclk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end
endmodule // wras_mem_model
`default_nettype wire

// >>> wras_core_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "wras_regs.vh"
module wras_core_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       acc_valid,
    input wire logic [2:0] acc_mode,
    input wire logic [7:0] acc_field,
    input wire logic       acc_pair,
    input wire logic       acc_done,
    input wire logic [7:0] acc_addr_hi,
    input wire logic [7:0] acc_addr_lo,
    input wire logic       acc_set2,
    input wire logic       acc_none,
    input wire logic       acc_invalid,
    input wire logic       stk_valid,
    input wire logic       stk_ready,
    input wire logic [2:0] stk_cmd,
    input wire logic [7:0] stk_data_in,
    input wire logic       stk_done,
    input wire logic       mem_we,
    input wire logic [7:0] mem_wdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take(logic [2:0] c);
        stk_valid && stk_ready && stk_cmd == c;
    endsequence
    sequence s_acc(logic [2:0] m);
        acc_valid && acc_mode == m && !acc_pair;
    endsequence
    a_work_low: assert property (s_acc(`WRAS_MODE_WORK4) |=>
        acc_done && acc_addr_lo[2:0] == $past(acc_field[2:0])) else $error("work bits");
    a_tag_decode: assert property (s_acc(`WRAS_MODE_REG) && acc_field[7:4] == `WRAS_WORK_TAG
        |=> !acc_none && acc_addr_lo[2:0] == $past(acc_field[2:0])) else $error("tag decode");
    a_direct_set1: assert property (s_acc(`WRAS_MODE_REG) && acc_field[7:4] != `WRAS_WORK_TAG
        |=> acc_addr_lo == $past(acc_field) && !acc_set2) else $error("direct address");
    a_set2_reach: assert property (acc_valid && acc_field >= `WRAS_SET2_BASE &&
        acc_mode inside {`WRAS_MODE_IND_REG, `WRAS_MODE_INDEXED} |=> acc_set2)
        else $error("set 2 flag");
    a_pair_even: assert property (acc_valid && acc_pair && acc_mode == `WRAS_MODE_REG &&
        acc_field[7:4] != `WRAS_WORK_TAG && !acc_field[0] |=> acc_addr_hi == $past(acc_field)
        && acc_addr_lo == $past(acc_field) + 8'h01) else $error("pair layout");
    a_pair_odd: assert property (acc_valid && acc_pair && acc_mode == `WRAS_MODE_REG
        && acc_field[0] |=> acc_invalid) else $error("odd pair");
    a_no_regaddr: assert property (acc_valid &&
        acc_mode inside {[`WRAS_MODE_DIRECT:`WRAS_MODE_IMMEDIATE]} |=> acc_none)
        else $error("no register address");
    a_push_steps: assert property (s_take(`WRAS_STK_PUSH) |=> !stk_ready
        ##1 (mem_we && mem_wdata == $past(stk_data_in, 2)) ##1 stk_done) else $error("push");
    a_call_len: assert property (s_take(`WRAS_STK_CALL) |-> ##4 stk_done)
        else $error("call length");
    a_ret_len: assert property (s_take(`WRAS_STK_RET) |-> ##8 stk_done)
        else $error("return length");
    a_intr_len: assert property (s_take(`WRAS_STK_INTR) |-> ##5 stk_done)
        else $error("interrupt entry length");
    a_interrupt_return_len: assert property (s_take(`WRAS_STK_INTERRUPT_RETURN) |-> ##11 stk_done)
        else $error("interrupt return length");
endmodule // wras_core_props
bind wras_core wras_core_props u_props (.*);
`default_nettype wire

// >>> wras_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "wras_regs.vh"
module wras_core_tb;
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        ptr_load_first = 1'h0, ptr_load_second = 1'h0;
    logic        acc_valid = 1'h0, acc_pair = 1'h0, stk_valid = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0]  ptr_load_data = 8'h00, acc_field = 8'h00, stk_flags_in = 8'h00;
    logic [7:0]  stk_data_in = 8'h00;
    logic [2:0]  acc_mode = 3'h0, stk_cmd = 3'h0;
    logic [15:0] stk_pc_in = 16'h0000;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         acc_done, acc_set2, acc_none, acc_invalid, stk_ready, stk_done;
    wire  [7:0]  acc_addr_hi, acc_addr_lo, stk_flags_out, stk_data_out;
    wire  [15:0] stk_pc_out;
    wire         mem_we, mem_re;
    wire  [7:0]  mem_addr, mem_wdata, mem_rdata;
    int          miscompares = 0, tests_run = 0, n;
    always #50 aclk = ~aclk;
    wras_core dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hF), .s_axi_arprot(3'h0),
        .acc_ready());
    wras_mem_model mem_model (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic guard();
        if (n >= 40) begin
            miscompares++;
            $display("Error at %0t ns: wait timed out", $time);
            complete_run();
        end
    endtask
    // Every bus, access and stack task starts on a fresh edge.
    task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        guard();
        chk(s_axi_bresp, `WRAS_RESP_OKAY);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        guard();
        chk({s_axi_rresp, s_axi_rdata}, {er, ed});
        s_axi_rready <= 1'h0;
    endtask
    task automatic acc(input logic [2:0] m, input logic [7:0] f, input logic p,
                       input logic [15:0] hl, input logic [2:0] fl);
        @(posedge aclk);
        acc_valid <= 1'h1;
        acc_mode <= m;
        acc_field <= f;
        acc_pair <= p;
        @(posedge aclk);
        acc_valid <= 1'h0;
        @(posedge aclk);
        chk({acc_done, acc_set2, acc_none, acc_invalid}, {1'h1, fl});
        if (fl == 3'h0) chk({acc_addr_hi, acc_addr_lo}, hl);
    endtask
    task automatic stk(input logic [2:0] c, input logic [15:0] pc, input logic [7:0] fl);
        @(posedge aclk);
        stk_valid <= 1'h1;
        stk_cmd <= c;
        stk_pc_in <= pc;
        stk_flags_in <= fl;
        stk_data_in <= 8'h5A;
        @(posedge aclk);
        stk_valid <= 1'h0;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (stk_done) break;
        end
        guard();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(`WRAS_IDX_SLICE_FIRST, 32'hC0, `WRAS_RESP_OKAY);
        axi_rd(`WRAS_IDX_SLICE_SECOND, 32'hC8, `WRAS_RESP_OKAY);
        axi_rd(8'h01, 32'h0, `WRAS_RESP_SLVERR);
        acc(`WRAS_MODE_WORK4, 8'h03, 1'h0, 16'hC3C3, 3'h0);
        acc(`WRAS_MODE_WORK4, 8'h0A, 1'h0, 16'hCACA, 3'h0);
        @(posedge aclk);
        ptr_load_data <= 8'h77;
        ptr_load_first <= 1'h1;
        @(posedge aclk);
        ptr_load_first <= 1'h0;
        axi_wr(`WRAS_IDX_SLICE_SECOND, 32'hFFFFFFAB);
        axi_rd(`WRAS_IDX_SLICE_FIRST, 32'h77, `WRAS_RESP_OKAY);
        axi_rd(`WRAS_IDX_SLICE_SECOND, 32'hAB, `WRAS_RESP_OKAY);
        acc(`WRAS_MODE_WORK4, 8'h06, 1'h0, 16'h7676, 3'h0);
        acc(`WRAS_MODE_WORK4, 8'h0B, 1'h0, 16'hABAB, 3'h0);
        acc(`WRAS_MODE_REG, 8'hCB, 1'h0, 16'hABAB, 3'h0);
        acc(`WRAS_MODE_REG, 8'hC2, 1'h0, 16'h7272, 3'h0);
        acc(`WRAS_MODE_REG, 8'hD5, 1'h0, 16'hD5D5, 3'h0);
        acc(`WRAS_MODE_REG, 8'h40, 1'h1, 16'h4041, 3'h0);
        acc(`WRAS_MODE_REG, 8'h41, 1'h1, 16'h0000, 3'h1);
        axi_rd(`WRAS_IDX_STATUS, 32'h4002, `WRAS_RESP_OKAY);
        acc(`WRAS_MODE_IND_REG, 8'hE0, 1'h0, 16'h0000, 3'h4);
        acc(`WRAS_MODE_INDEXED, 8'hC5, 1'h0, 16'h0000, 3'h4);
        for (int m = 3; m < 7; m++) acc(m[2:0], 8'h10, 1'h0, 16'h0000, 3'h2);
        axi_wr(`WRAS_IDX_SP_HIGH, 32'h12);
        axi_wr(`WRAS_IDX_SP_LOW, 32'h00);
        stk(`WRAS_STK_PUSH, 16'h0000, 8'h00);
        chk(mem_model.mem[8'hFF], 8'h5A);
        axi_rd(`WRAS_IDX_SP_LOW, 32'hFF, `WRAS_RESP_OKAY);
        axi_rd(`WRAS_IDX_SP_HIGH, 32'h11, `WRAS_RESP_OKAY);
        stk(`WRAS_STK_POP, 16'h0000, 8'h00);
        chk(stk_data_out, 8'h5A);
        axi_rd(`WRAS_IDX_SP_HIGH, 32'h12, `WRAS_RESP_OKAY);
        axi_wr(`WRAS_IDX_SP_LOW, 32'hFF);
        stk(`WRAS_STK_CALL, 16'hBEEF, 8'h00);
        chk({mem_model.mem[8'hFE], mem_model.mem[8'hFD]}, 16'hEFBE);
        stk(`WRAS_STK_INTR, 16'h1234, 8'hC5);
        chk({mem_model.mem[8'hFC], mem_model.mem[8'hFB], mem_model.mem[8'hFA]}, 24'h3412C5);
        stk(`WRAS_STK_INTERRUPT_RETURN, 16'h0000, 8'h00);
        chk({stk_pc_out, stk_flags_out}, 24'h1234C5);
        stk(`WRAS_STK_RET, 16'h0000, 8'h00);
        chk(stk_pc_out, 16'hBEEF);
        axi_rd(`WRAS_IDX_SP_LOW, 32'hFF, `WRAS_RESP_OKAY);
        axi_rd(`WRAS_IDX_SP_HIGH, 32'h12, `WRAS_RESP_OKAY);
        complete_run();
    end
endmodule // wras_core_tb
`default_nettype wire
